// *** hdl/meirq_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module meirq_top
  import meirq_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1
) (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_b_in,
  // special-function register port
  input  wire logic [7:0]              sfr_addr_in,
  input  wire logic                    sfr_wr_in,
  input  wire logic                    sfr_rd_in,
  input  wire logic [7:0]              sfr_wdata_in,
  output logic [7:0]                   sfr_rdata_out,
  // metering events, one-cycle pulses, plus the zero-crossing timeout half-cycle count
  input  wire logic                    first_pulse_in,
  input  wire logic                    second_pulse_in,
  input  wire logic [2:0]              energy_overflow_in,
  input  wire logic [2:0]              energy_half_full_in,
  input  wire logic                    new_waveform_sample_in,
  input  wire logic                    current_peak_in,
  input  wire logic                    voltage_peak_in,
  input  wire logic                    cycle_end_in,
  input  wire logic                    half_line_cycle_in,
  input  wire logic                    zero_crossing_in,
  input  wire logic [ZERO_CROSSING_TIMEOUT_COUNT_W-1:0] zero_crossing_timeout_count_in,
  // interrupt to core
  output logic                         metering_irq_out
);
  logic [7:0] energy_event_irq_enable_ff;
  logic [7:0] nxt_energy_enable;
  logic [7:0] waveform_line_irq_enable_ff;
  logic [7:0] nxt_waveform_enable;
  logic [7:0] middle_status_ff;
  logic [7:0] nxt_middle_status;
  logic [7:0] high_status_ff;
  logic [7:0] nxt_high_status;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] middle_events;
  logic [7:0] high_events;
  logic [7:0] energy_mask;
  logic       zx_timeout;
  logic       summary_flag;

  // one address match shared by every register write path
  function automatic logic write_hit(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  meirq_zx_timeout u_zx_timeout (
    .clock_in         (clock_in),
    .rst_b_in         (rst_b_in),
    .half_cycle_in    (half_line_cycle_in),
    .zero_crossing_in (zero_crossing_in),
    .timeout_count_in (zero_crossing_timeout_count_in),
    .timeout_out      (zx_timeout)
  );

  // reactive functions vanish in the reduced variant
  assign energy_mask = HAS_REACTIVE ? 8'hFF : ~REACTIVE_MASK;

  // pulse events come from the internal generator, not the pin, so the pin mode is ignored
  always_comb begin
    middle_events                    = 8'h00;
    middle_events[BIT_SECOND_PULSE]  = second_pulse_in;
    middle_events[BIT_FIRST_PULSE]   = first_pulse_in;
    middle_events[BIT_APPARENT_OVF]  = energy_overflow_in[2];
    middle_events[BIT_REACTIVE_OVF]  = energy_overflow_in[1];
    middle_events[BIT_ACTIVE_OVF]    = energy_overflow_in[0];
    middle_events[BIT_APPARENT_HALF] = energy_half_full_in[2];
    middle_events[BIT_REACTIVE_HALF] = energy_half_full_in[1];
    middle_events[BIT_ACTIVE_HALF]   = energy_half_full_in[0];
    middle_events                    = middle_events & energy_mask;
    high_events                      = 8'h00;
    high_events[BIT_NEW_WAVEFORM]    = new_waveform_sample_in;
    high_events[BIT_CURRENT_PEAK]    = current_peak_in;
    high_events[BIT_VOLTAGE_PEAK]    = voltage_peak_in;
    high_events[BIT_CYCLE_END]       = cycle_end_in;
    high_events[BIT_ZX_TIMEOUT]      = zx_timeout;
    high_events[BIT_ZX_DETECTED]     = zero_crossing_in;
  end

  // status flags: write one to clear, a new event in the same cycle wins
  always_comb begin
    nxt_middle_status = middle_status_ff;
    nxt_high_status   = high_status_ff;
    if (write_hit(sfr_wr_in, sfr_addr_in, MIDDLE_STATUS_ADDR)) begin
      nxt_middle_status = middle_status_ff & ~sfr_wdata_in;
    end
    if (write_hit(sfr_wr_in, sfr_addr_in, HIGH_STATUS_ADDR)) begin
      nxt_high_status = high_status_ff & ~sfr_wdata_in;
    end
    nxt_middle_status = nxt_middle_status | middle_events;
    nxt_high_status   = (nxt_high_status | high_events) & HIGH_STATUS_MASK;
  end

  // enable registers
  always_comb begin
    nxt_energy_enable   = energy_event_irq_enable_ff;
    nxt_waveform_enable = waveform_line_irq_enable_ff;
    if (write_hit(sfr_wr_in, sfr_addr_in, ENERGY_EVENT_IRQ_ENABLE_ADDR)) begin
      nxt_energy_enable = sfr_wdata_in & energy_mask;
    end
    if (write_hit(sfr_wr_in, sfr_addr_in, WAVEFORM_LINE_IRQ_ENABLE_ADDR)) begin
      nxt_waveform_enable = sfr_wdata_in & HIGH_ENABLE_MASK;
    end
  end

  // each enabled flag feeds the summary; it drops by itself once they clear
  assign summary_flag = |(middle_status_ff & energy_event_irq_enable_ff)
                      | |(high_status_ff & waveform_line_irq_enable_ff);

  // read data registered so the data output comes from a flip-flop
  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        ENERGY_EVENT_IRQ_ENABLE_ADDR:  nxt_rdata = energy_event_irq_enable_ff;
        WAVEFORM_LINE_IRQ_ENABLE_ADDR: nxt_rdata = waveform_line_irq_enable_ff;
        LOW_STATUS_ADDR:               nxt_rdata = {summary_flag, 7'h00};
        MIDDLE_STATUS_ADDR:            nxt_rdata = middle_status_ff;
        HIGH_STATUS_ADDR:              nxt_rdata = high_status_ff;
        default:                       nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      energy_event_irq_enable_ff  <= ENABLE_RESET;
      waveform_line_irq_enable_ff <= ENABLE_RESET;
      middle_status_ff            <= STATUS_RESET;
      high_status_ff              <= STATUS_RESET;
      rdata_ff                    <= 8'h00;
    end else begin
      energy_event_irq_enable_ff  <= nxt_energy_enable;
      waveform_line_irq_enable_ff <= nxt_waveform_enable;
      middle_status_ff            <= nxt_middle_status;
      high_status_ff              <= nxt_high_status;
      rdata_ff                    <= nxt_rdata;
    end
  end

  assign sfr_rdata_out    = rdata_ff;
  assign metering_irq_out = summary_flag;

  property p_second_pulse;
    @(posedge clock_in) disable iff (!rst_b_in)
      (second_pulse_in && energy_event_irq_enable_ff[BIT_SECOND_PULSE] && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_second_pulse: assert property (p_second_pulse) else $error("second pulse no irq");

  property p_first_pulse;
    @(posedge clock_in) disable iff (!rst_b_in)
      (first_pulse_in && energy_event_irq_enable_ff[BIT_FIRST_PULSE] && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_first_pulse: assert property (p_first_pulse) else $error("first pulse no irq");

  property p_overflow;
    @(posedge clock_in) disable iff (!rst_b_in)
      (|(middle_status_ff & energy_event_irq_enable_ff & 8'h38)) |-> metering_irq_out;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not pending");

  property p_half_full;
    @(posedge clock_in) disable iff (!rst_b_in)
      (|(middle_status_ff & energy_event_irq_enable_ff & 8'h07)) |-> metering_irq_out;
  endproperty
  a_half_full: assert property (p_half_full) else $error("half full not pending");

  property p_waveform;
    @(posedge clock_in) disable iff (!rst_b_in)
      (new_waveform_sample_in && waveform_line_irq_enable_ff[BIT_NEW_WAVEFORM] && !sfr_wr_in)
      |=> metering_irq_out ##1 (metering_irq_out || $past(sfr_wr_in));
  endproperty
  a_waveform: assert property (p_waveform) else $error("waveform irq lost");

  property p_summary_clear;
    @(posedge clock_in) disable iff (!rst_b_in)
      ((middle_status_ff & energy_event_irq_enable_ff) == 8'h00 &&
       (high_status_ff & waveform_line_irq_enable_ff) == 8'h00) |-> !metering_irq_out;
  endproperty
  a_summary_clear: assert property (p_summary_clear) else $error("irq without flag");

  property p_pulse_flag;
    @(posedge clock_in) disable iff (!rst_b_in)
      first_pulse_in |=> middle_status_ff[BIT_FIRST_PULSE];
  endproperty
  a_pulse_flag: assert property (p_pulse_flag) else $error("pulse flag not set");

  property p_reserved;
    @(posedge clock_in) disable iff (!rst_b_in)
      waveform_line_irq_enable_ff[7:6] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved enable set");

  property p_reset_enables;
    @(posedge clock_in) !rst_b_in |=> (energy_event_irq_enable_ff == 8'h00) && !metering_irq_out;
  endproperty
  a_reset_enables: assert property (p_reset_enables) else $error("enable not reset");

  property p_write_clear;
    @(posedge clock_in) disable iff (!rst_b_in)
      (sfr_wr_in && sfr_addr_in == HIGH_STATUS_ADDR && sfr_wdata_in[BIT_ZX_DETECTED]
       && !zero_crossing_in) |=> !high_status_ff[BIT_ZX_DETECTED];
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("flag not cleared");

  property p_peak;
    @(posedge clock_in) disable iff (!rst_b_in)
      (((current_peak_in && waveform_line_irq_enable_ff[BIT_CURRENT_PEAK]) ||
        (voltage_peak_in && waveform_line_irq_enable_ff[BIT_VOLTAGE_PEAK])) && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_peak: assert property (p_peak) else $error("peak irq lost");

  property p_cycle_end;
    @(posedge clock_in) disable iff (!rst_b_in)
      (cycle_end_in && waveform_line_irq_enable_ff[BIT_CYCLE_END] && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("cycle end irq lost");

  property p_zx_timeout;
    @(posedge clock_in) disable iff (!rst_b_in)
      (zx_timeout && waveform_line_irq_enable_ff[BIT_ZX_TIMEOUT] && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_zx_timeout: assert property (p_zx_timeout) else $error("timeout irq lost");

  property p_zx_detected;
    @(posedge clock_in) disable iff (!rst_b_in)
      (zero_crossing_in && waveform_line_irq_enable_ff[BIT_ZX_DETECTED] && !sfr_wr_in)
      |=> metering_irq_out;
  endproperty
  a_zx_detected: assert property (p_zx_detected) else $error("crossing irq lost");

  property p_reduced;
    @(posedge clock_in) disable iff (!rst_b_in)
      !HAS_REACTIVE |-> ((energy_event_irq_enable_ff & REACTIVE_MASK) == 8'h00) &&
                        ((middle_status_ff & REACTIVE_MASK) == 8'h00);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reactive bit in reduced variant");

  property p_timeout_flag;
    @(posedge clock_in) disable iff (!rst_b_in)
      zx_timeout |=> high_status_ff[BIT_ZX_TIMEOUT];
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag not set");

  property p_overflow_flag;
    @(posedge clock_in) disable iff (!rst_b_in)
      energy_overflow_in[0] |=> middle_status_ff[BIT_ACTIVE_OVF];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set");

  property p_enable_write;
    @(posedge clock_in) disable iff (!rst_b_in)
      write_hit(sfr_wr_in, sfr_addr_in, ENERGY_EVENT_IRQ_ENABLE_ADDR)
      |=> energy_event_irq_enable_ff == ($past(sfr_wdata_in) & energy_mask);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_irq_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
      (metering_irq_out && !sfr_wr_in) |=> metering_irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");

  c_pulse_irq: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    second_pulse_in ##1 metering_irq_out);
  c_timeout: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    zx_timeout ##1 high_status_ff[BIT_ZX_TIMEOUT]);
  c_irq_drop: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    metering_irq_out ##1 !metering_irq_out);
  c_waveform_irq: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    new_waveform_sample_in ##1 metering_irq_out);
  c_late_enable: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    ((|middle_status_ff) && !metering_irq_out) ##1 metering_irq_out);
endmodule
`default_nettype wire

// *** hdl/meirq_pkg.sv ***
package meirq_pkg;
  // special-function register addresses
  localparam logic [7:0] ENERGY_EVENT_IRQ_ENABLE_ADDR  = 8'hDA;
  localparam logic [7:0] WAVEFORM_LINE_IRQ_ENABLE_ADDR = 8'hDB;
  localparam logic [7:0] LOW_STATUS_ADDR               = 8'hDC;
  localparam logic [7:0] MIDDLE_STATUS_ADDR            = 8'hDD;
  localparam logic [7:0] HIGH_STATUS_ADDR              = 8'hDE;
  // reset values
  localparam logic [7:0] ENABLE_RESET                  = 8'h00;
  localparam logic [7:0] STATUS_RESET                  = 8'h00;
  // middle register field positions
  localparam int unsigned BIT_SECOND_PULSE     = 7;
  localparam int unsigned BIT_FIRST_PULSE      = 6;
  localparam int unsigned BIT_APPARENT_OVF     = 5;
  localparam int unsigned BIT_REACTIVE_OVF     = 4;
  localparam int unsigned BIT_ACTIVE_OVF       = 3;
  localparam int unsigned BIT_APPARENT_HALF    = 2;
  localparam int unsigned BIT_REACTIVE_HALF    = 1;
  localparam int unsigned BIT_ACTIVE_HALF      = 0;
  // high register field positions
  localparam int unsigned BIT_NEW_WAVEFORM     = 5;
  localparam int unsigned BIT_CURRENT_PEAK     = 4;
  localparam int unsigned BIT_VOLTAGE_PEAK     = 3;
  localparam int unsigned BIT_CYCLE_END        = 2;
  localparam int unsigned BIT_ZX_TIMEOUT       = 1;
  localparam int unsigned BIT_ZX_DETECTED      = 0;
  // low register field position
  localparam int unsigned BIT_SUMMARY_FLAG     = 7;
  // writable masks
  localparam logic [7:0] HIGH_ENABLE_MASK      = 8'h3F;
  localparam logic [7:0] REACTIVE_MASK         = 8'h12;
  localparam logic [7:0] HIGH_STATUS_MASK      = 8'h3F;
  // zero-crossing timeout counter
  localparam int unsigned ZERO_CROSSING_TIMEOUT_COUNT_W         = 12;
  localparam logic [11:0] ZERO_CROSSING_TIMEOUT_COUNT_RESET     = 12'hFFF;
endpackage

// *** hdl/meirq_zx_timeout.sv ***
`timescale 1ns/100ps
`default_nettype none
module meirq_zx_timeout
  import meirq_pkg::*;
(
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_b_in,
  // line events
  input  wire logic                    half_cycle_in,
  input  wire logic                    zero_crossing_in,
  input  wire logic [ZERO_CROSSING_TIMEOUT_COUNT_W-1:0] timeout_count_in,
  // timeout event
  output logic                         timeout_out
);
  logic [ZERO_CROSSING_TIMEOUT_COUNT_W-1:0] count_ff;
  logic [ZERO_CROSSING_TIMEOUT_COUNT_W-1:0] nxt_count;
  logic                    timeout_ff;
  logic                    nxt_timeout;

  // counts half cycles without a crossing; fires once, then waits for a crossing
  always_comb begin
    nxt_count   = count_ff;
    nxt_timeout = 1'b0;
    if (zero_crossing_in) begin
      nxt_count = '0;
    end else if (half_cycle_in && (count_ff != timeout_count_in)) begin
      nxt_count = count_ff + {{(ZERO_CROSSING_TIMEOUT_COUNT_W-1){1'b0}}, 1'b1};
      if (nxt_count == timeout_count_in) begin
        nxt_timeout = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      count_ff   <= '0;
      timeout_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      timeout_ff <= nxt_timeout;
    end
  end

  assign timeout_out = timeout_ff;
endmodule
`default_nettype wire

// *** tb/meirq_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module meirq_core_model
  import meirq_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // interrupt request level from the metering block
  input  wire logic       irq_in,
  // number of requests taken
  output logic [7:0]      rise_count_out
);
  logic irq_q_ff;
  // the core latches a pending request on each rising level, so a level
  // that stays high is one request only
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      irq_q_ff       <= 1'b0;
      rise_count_out <= 8'h00;
    end else begin
      irq_q_ff <= irq_in;
      if (irq_in && !irq_q_ff) begin
        rise_count_out <= rise_count_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench
  import meirq_pkg::*;
;
  logic       clock_in;
  logic       rst_b_in;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rd_v;
  logic       wr;
  logic       rd;
  logic       irq;
  logic       half;
  logic [7:0] ev_m;
  logic [5:0] ev_h;
  logic [7:0] rise_cnt;
  logic [7:0] rdata_lite;
  logic       irq_lite;
  logic [11:0] zx_limit;
  int         bad_count;
  int         comparisons;

  meirq_top u_dut (
    .clock_in                       (clock_in),
    .rst_b_in                       (rst_b_in),
    .sfr_addr_in                    (addr),
    .sfr_wr_in                      (wr),
    .sfr_rd_in                      (rd),
    .sfr_wdata_in                   (wdata),
    .sfr_rdata_out                  (rdata),
    .first_pulse_in                 (ev_m[6]),
    .second_pulse_in                (ev_m[7]),
    .energy_overflow_in             (ev_m[5:3]),
    .energy_half_full_in            (ev_m[2:0]),
    .new_waveform_sample_in         (ev_h[5]),
    .current_peak_in                (ev_h[4]),
    .voltage_peak_in                (ev_h[3]),
    .cycle_end_in                   (ev_h[2]),
    .half_line_cycle_in             (half),
    .zero_crossing_in               (ev_h[0]),
    .zero_crossing_timeout_count_in (zx_limit),
    .metering_irq_out               (irq)
  );

  // reduced variant on the same bus and events; only its reactive bits differ
  meirq_top #(
    .HAS_REACTIVE (1'b0)
  ) u_dut_lite (
    .clock_in                       (clock_in),
    .rst_b_in                       (rst_b_in),
    .sfr_addr_in                    (addr),
    .sfr_wr_in                      (wr),
    .sfr_rd_in                      (rd),
    .sfr_wdata_in                   (wdata),
    .sfr_rdata_out                  (rdata_lite),
    .first_pulse_in                 (ev_m[6]),
    .second_pulse_in                (ev_m[7]),
    .energy_overflow_in             (ev_m[5:3]),
    .energy_half_full_in            (ev_m[2:0]),
    .new_waveform_sample_in         (ev_h[5]),
    .current_peak_in                (ev_h[4]),
    .voltage_peak_in                (ev_h[3]),
    .cycle_end_in                   (ev_h[2]),
    .half_line_cycle_in             (half),
    .zero_crossing_in               (ev_h[0]),
    .zero_crossing_timeout_count_in (zx_limit),
    .metering_irq_out               (irq_lite)
  );

  meirq_core_model u_core (
    .clock_in       (clock_in),
    .rst_b_in       (rst_b_in),
    .irq_in         (irq),
    .rise_count_out (rise_cnt)
  );

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock_in);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(negedge clock_in);
    addr = a;
    rd = 1'b1;
    @(negedge clock_in);
    rd = 1'b0;
    rd_v = rdata;
  endtask

  // the timeout event needs a crossing first so the half-cycle count starts clean
  task automatic fire(input bit hi, input int b);
    @(negedge clock_in);
    if (hi && b == 1) begin
      ev_h[0] = 1'b1;
      @(negedge clock_in);
      ev_h[0] = 1'b0;
      for (int i = 1; i <= int'(zx_limit); i++) begin
        half = 1'b1;
        @(negedge clock_in);
        half = 1'b0;
        @(negedge clock_in);
        if (i == int'(zx_limit) - 1) begin
          rd_reg(HIGH_STATUS_ADDR);
          chk("no early timeout", rd_v & 8'h02, 8'h00);
        end
      end
      repeat (2) @(negedge clock_in);
    end else begin
      if (hi) ev_h[b] = 1'b1;
      else ev_m[b] = 1'b1;
      @(negedge clock_in);
      ev_m = 8'h00;
      ev_h = 6'h00;
    end
  endtask

  task automatic bit_test(input bit hi, input int b);
    logic [7:0] en_a;
    logic [7:0] st_a;
    logic [7:0] m;
    en_a = hi ? WAVEFORM_LINE_IRQ_ENABLE_ADDR : ENERGY_EVENT_IRQ_ENABLE_ADDR;
    st_a = hi ? HIGH_STATUS_ADDR : MIDDLE_STATUS_ADDR;
    m = 8'h01 << b;
    wr_reg(st_a, 8'hFF);
    wr_reg(en_a, m);
    fire(hi, b);
    @(negedge clock_in);
    chk("irq enabled", {7'h00, irq}, 8'h01);
    chk("reduced irq", {7'h00, irq_lite},
        (!hi && ((m & REACTIVE_MASK) != 8'h00)) ? 8'h00 : 8'h01);
    rd_reg(LOW_STATUS_ADDR);
    chk("summary set", rd_v & 8'h80, 8'h80);
    wr_reg(st_a, m);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    rd_reg(LOW_STATUS_ADDR);
    chk("summary clear", rd_v & 8'h80, 8'h00);
    wr_reg(en_a, 8'h00);
    fire(hi, b);
    chk("irq masked", {7'h00, irq}, 8'h00);
    rd_reg(st_a);
    chk("flag", rd_v & m, m);
    wr_reg(en_a, m);
    chk("irq late enable", {7'h00, irq}, 8'h01);
    wr_reg(en_a, 8'h00);
    chk("irq enable off", {7'h00, irq}, 8'h00);
    wr_reg(st_a, m);
    $display("test done: event hi %0d bit %0d", hi, b);
  endtask

  task automatic give_verdict();
    $display("counts: comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // whole run is well under 2000 cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_b_in = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    half = 1'b0;
    ev_m = 8'h00;
    ev_h = 6'h00;
    zx_limit = 12'h003;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(negedge clock_in);
    rst_b_in = 1'b1;
    rd_reg(ENERGY_EVENT_IRQ_ENABLE_ADDR);
    chk("mid enable reset", rd_v, ENABLE_RESET);
    rd_reg(WAVEFORM_LINE_IRQ_ENABLE_ADDR);
    chk("high enable reset", rd_v, ENABLE_RESET);
    chk("irq after reset", {7'h00, irq}, 8'h00);
    wr_reg(ENERGY_EVENT_IRQ_ENABLE_ADDR, 8'h5A);
    rd_reg(ENERGY_EVENT_IRQ_ENABLE_ADDR);
    chk("mid enable rw", rd_v, 8'h5A);
    chk("reduced enable rw", rdata_lite, 8'h5A & ~REACTIVE_MASK);
    wr_reg(WAVEFORM_LINE_IRQ_ENABLE_ADDR, 8'hFF);
    rd_reg(WAVEFORM_LINE_IRQ_ENABLE_ADDR);
    chk("high enable rw", rd_v, 8'h3F);
    wr_reg(WAVEFORM_LINE_IRQ_ENABLE_ADDR, 8'hC0);
    rd_reg(WAVEFORM_LINE_IRQ_ENABLE_ADDR);
    chk("reserved bits", rd_v, 8'h00);
    wr_reg(ENERGY_EVENT_IRQ_ENABLE_ADDR, 8'h00);
    rd_reg(8'h10);
    chk("unmapped read", rd_v, 8'h00);
    $display("test done: registers");
    for (int b = 7; b >= 0; b--) bit_test(1'b0, b);
    for (int b = 5; b >= 0; b--) bit_test(1'b1, b);
    // two requests per event test reach the core model
    chk("core request count", rise_cnt, 8'h1C);
    give_verdict();
  end
endmodule
`default_nettype wire
